// [inc/dfm_defines.svh]
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH

// dictionary indices of the objects held here
`define DFM_IDX_SUMMARY 16'h1001
`define DFM_IDX_HISTORY 16'h1003
`define DFM_IDX_MASK 16'h2182
`define DFM_IDX_LATCHED 16'h2183
`define DFM_IDX_WINDOW 16'h2120
`define DFM_IDX_STATUS 16'h1002
// summary byte bit positions
`define DFM_SUM_GENERIC 0
`define DFM_SUM_CURRENT 1
`define DFM_SUM_VOLTAGE 2
`define DFM_SUM_TEMP 3
`define DFM_SUM_MOTION 7
// event / mask bit positions
`define DFM_EV_CRC 0
`define DFM_EV_INTERNAL 1
`define DFM_EV_SHORT 2
`define DFM_EV_AMP_TEMP 3
`define DFM_EV_MOTOR_TEMP 4
`define DFM_EV_OVER_V 5
`define DFM_EV_UNDER_V 6
`define DFM_EV_FEEDBACK 7
`define DFM_EV_PHASING 8
`define DFM_EV_TRACKING 9
`define DFM_EV_I2T 10
`define DFM_EV_FPGA 11
`define DFM_EV_CMD_LOST 12
// writable mask bits, fixed-set bits, fatal bits
`define DFM_MASK_WR 32'h000017FC
`define DFM_MASK_FIXED 32'h00000803
`define DFM_MASK_RESET 32'h00000803
`define DFM_FATAL 32'h00000803
`define DFM_WINDOW_RESET 32'h00000000
// manufacturer status bits
`define DFM_STAT_TRACK_WARN 18
`define DFM_STAT_FAULT 22
// history depth
`define DFM_HIST_DEPTH 8
// short-circuit recovery time
`define DFM_SHORT_MS 100
`define DFM_CLK_MHZ 250
`define DFM_SHORT_CYC (`DFM_SHORT_MS * 1000 * `DFM_CLK_MHZ)

`endif

// [inc/dfm_pkg.sv]
package dfm_pkg;
  typedef enum logic [2:0] {
    DFM_SC_RUN = 3'b001,
    DFM_SC_OFF = 3'b010,
    DFM_SC_LATCH = 3'b100
  } dfm_short_state_t;
  typedef logic [31:0] dfm_word_t;
endpackage

// [inc/dfm_hist_if.sv]
`timescale 1ns/1ps
interface dfm_hist_if;
  logic push;
  logic [31:0] push_data;
  logic clear;
  logic [3:0] rd_sel;
  logic [31:0] rd_data;
  logic [3:0] count;
  modport owner (output push, output push_data, output clear, output rd_sel,
    input rd_data, input count);
  modport store (input push, input push_data, input clear, input rd_sel,
    output rd_data, output count);
endinterface

// [rtl/dfm_hist_mem.sv]
`timescale 1ns/1ps
`include "dfm_defines.svh"
module dfm_hist_mem
  import dfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  dfm_hist_if.store hist
);
  dfm_word_t slot_r [1:`DFM_HIST_DEPTH];
  logic [3:0] count_r;

  // newest in slot 1, older entries move down, oldest dropped when full
  always_ff @(posedge core_clk) begin
    if (hist.push) begin
      slot_r[1] <= hist.push_data; // [RQ7] [RQ10]
      for (int i = 2; i <= `DFM_HIST_DEPTH; i++) begin
        slot_r[i] <= slot_r[i-1]; // [RQ25]
      end
    end
  end

  // count of valid entries, saturating at depth
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_r <= 4'h0;
    end else if (hist.clear) begin
      count_r <= hist.push ? 4'h1 : 4'h0; // [RQ9] an error arriving with the clear survives
    end else if (hist.push && count_r != 4'(`DFM_HIST_DEPTH)) begin
      count_r <= count_r + 4'h1; // [RQ8] [RQ11]
    end
  end

  // registered read, invalid slots read as zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hist.rd_data <= 32'h00000000;
    end else if (hist.rd_sel == 4'h0) begin
      hist.rd_data <= {28'h0000000, count_r}; // [RQ8]
    end else if (hist.rd_sel <= count_r) begin
      hist.rd_data <= slot_r[hist.rd_sel];
    end else begin
      hist.rd_data <= 32'h00000000;
    end
  end

  assign hist.count = count_r;
endmodule

// [rtl/dfm_short_timer.sv]
`timescale 1ns/1ps
`include "dfm_defines.svh"
module dfm_short_timer
  import dfm_pkg::*;
#(
  parameter int SHORT_CYC = `DFM_SHORT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic short_evt,
  input wire logic latch_sel,
  input wire logic latch_clr,
  output logic outputs_off
);
  dfm_short_state_t state_r;
  logic [31:0] cnt_r;

  // short circuit: latch or switch off for the recovery time then re-enable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= DFM_SC_RUN;
      cnt_r <= 32'h00000000;
    end else begin
      unique case (state_r)
        DFM_SC_RUN: begin
          if (short_evt && latch_sel) begin
            state_r <= DFM_SC_LATCH; // [RQ15]
          end else if (short_evt) begin
            state_r <= DFM_SC_OFF; // [RQ15]
            cnt_r <= 32'(SHORT_CYC - 1);
          end
        end
        DFM_SC_OFF: begin
          if (cnt_r == 32'h00000000) begin
            state_r <= DFM_SC_RUN; // [RQ15]
          end else begin
            cnt_r <= cnt_r - 32'h00000001;
          end
        end
        DFM_SC_LATCH: begin
          if (latch_clr) begin
            state_r <= DFM_SC_RUN;
          end
        end
        default: state_r <= DFM_SC_RUN;
      endcase
    end
  end

  assign outputs_off = (state_r != DFM_SC_RUN);
endmodule

// [rtl/dfm_fault_manager.sv]
`timescale 1ns/1ps
`include "dfm_defines.svh"
// Overview of operation
// RQ1: summary bit 0 set on any error
// RQ2: bit 1 for short or encoder over-current
// RQ3: bit 2 for bus voltage out of range
// RQ4: bit 3 amp or sensed motor overtemperature
// RQ5: bit 4 unused, bits 5-6 reserved
// RQ6: bit 7 phasing, tracking or limit switch
// RQ7: new error into slot 1, shift older
// RQ8: slot 0 reports valid count 0 to 8
// RQ9: write zero empties history, nonzero rejected
// RQ10: entry low half code, high half info
// RQ11: at most eight history entries kept
// RQ12: tracking event and warning bit 18
// RQ13: mask bit one latches, zero does not
// RQ14: bits 0,1,11 fixed; fatal faults disable
// RQ15: short latches or disables for 100 ms
// RQ16: amp overtemp latches or self-recovers
// RQ17: motor temp input latches or self-recovers
// RQ18: bits 5,6 select voltage fault latching
// RQ19: bit 7 selects feedback fault latching
// RQ20: phasing latches or recovers on removal
// RQ21: tracking latches disabled or aborts move
// RQ22: bit 12 latches on command loss
// RQ23: write one clears latched, fatal stays
// RQ24: status bit 22 on any latched fault
// RQ25: full history drops oldest, count stays
// RQ26: reserved bits read zero, writes ignored
// RQ27: summary bits follow live conditions
module dfm_fault_manager
  import dfm_pkg::*;
#(
  parameter int SHORT_CYC = `DFM_SHORT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  // object access from the network side
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_subindex,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  // amplifier condition inputs, same clock
  input wire logic crc_fail,
  input wire logic selftest_fail,
  input wire logic fpga_fail,
  input wire logic short_circuit,
  input wire logic encoder_overcurrent,
  input wire logic feedback_loss,
  input wire logic bus_over_voltage,
  input wire logic bus_under_voltage,
  input wire logic amp_over_temp,
  input wire logic motor_temp_input,
  input wire logic motor_temp_enabled,
  input wire logic phasing_error,
  input wire logic limit_switch,
  input wire logic i2t_limited,
  input wire logic command_lost,
  input wire logic signed [31:0] position_error,
  // emergency error record to history
  input wire logic err_signal,
  input wire logic [15:0] err_code,
  input wire logic [15:0] err_info,
  // outputs to the amplifier
  output logic [7:0] error_summary,
  output logic [31:0] latched_faults,
  output logic tracking_warning,
  output logic fault_flag,
  output logic amp_disable,
  output logic abort_move
);
  dfm_word_t mask_r;
  dfm_word_t window_r;
  dfm_word_t latched_r;
  dfm_word_t event_w;
  logic [7:0] summary_r;
  logic track_r;
  logic track_d_r;
  logic abort_r;
  logic disable_r;
  logic short_off;
  logic hist_sel;
  logic hist_rd_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic err_r;
  logic [31:0] clr_bits;
  logic [31:0] abs_err;
  dfm_hist_if hist ();

  // magnitude of a signed value
  function automatic logic [31:0] dfm_abs(input logic signed [31:0] v);
    dfm_abs = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // one object address match
  function automatic logic dfm_hit(input logic [15:0] idx, input logic [15:0] want);
    dfm_hit = (idx == want);
  endfunction

  dfm_hist_mem u_hist (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .hist(hist.store)
  );

  dfm_short_timer #(
    .SHORT_CYC(SHORT_CYC)
  ) u_short (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .short_evt(short_circuit),
    .latch_sel(mask_r[`DFM_EV_SHORT]),
    .latch_clr(clr_bits[`DFM_EV_SHORT]),
    .outputs_off(short_off)
  );

  assign abs_err = dfm_abs(position_error);

  // tracking comparison against the programmed window
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      track_r <= 1'b0;
      track_d_r <= 1'b0;
    end else begin
      track_r <= (abs_err > window_r); // [RQ12]
      track_d_r <= track_r;
    end
  end

  // live event vector, one bit per mask position
  always_comb begin
    event_w = 32'h00000000;
    event_w[`DFM_EV_CRC] = crc_fail;
    event_w[`DFM_EV_INTERNAL] = selftest_fail;
    event_w[`DFM_EV_SHORT] = short_circuit;
    event_w[`DFM_EV_AMP_TEMP] = amp_over_temp;
    event_w[`DFM_EV_MOTOR_TEMP] = motor_temp_input && motor_temp_enabled;
    event_w[`DFM_EV_OVER_V] = bus_over_voltage;
    event_w[`DFM_EV_UNDER_V] = bus_under_voltage;
    event_w[`DFM_EV_FEEDBACK] = encoder_overcurrent || feedback_loss; // [RQ19]
    event_w[`DFM_EV_PHASING] = phasing_error;
    event_w[`DFM_EV_TRACKING] = track_r;
    event_w[`DFM_EV_I2T] = i2t_limited;
    event_w[`DFM_EV_FPGA] = fpga_fail;
    event_w[`DFM_EV_CMD_LOST] = command_lost;
  end

  // summary byte follows live conditions, reserved bits zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      summary_r <= 8'h00;
    end else begin
      summary_r <= 8'h00; // [RQ5] [RQ26] [RQ27]
      summary_r[`DFM_SUM_GENERIC] <= |event_w || limit_switch; // [RQ1]
      summary_r[`DFM_SUM_CURRENT] <= short_circuit || encoder_overcurrent; // [RQ2]
      summary_r[`DFM_SUM_VOLTAGE] <= bus_over_voltage || bus_under_voltage; // [RQ3]
      summary_r[`DFM_SUM_TEMP] <= amp_over_temp || event_w[`DFM_EV_MOTOR_TEMP]; // [RQ4]
      summary_r[`DFM_SUM_MOTION] <= phasing_error || track_r || limit_switch; // [RQ6]
    end
  end

  // object write strobes
  assign clr_bits = (obj_wr && dfm_hit(obj_index, `DFM_IDX_LATCHED)) ?
    (obj_wdata & ~`DFM_FATAL) : 32'h00000000;

  // mask object: writable bits only, fixed bits stay set
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask_r <= `DFM_MASK_RESET;
    end else if (obj_wr && dfm_hit(obj_index, `DFM_IDX_MASK)) begin
      mask_r <= (obj_wdata & `DFM_MASK_WR) | `DFM_MASK_FIXED; // [RQ14] [RQ26]
    end
  end

  // tracking window object
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      window_r <= `DFM_WINDOW_RESET;
    end else if (obj_wr && dfm_hit(obj_index, `DFM_IDX_WINDOW)) begin
      window_r <= obj_wdata;
    end
  end

  // latched faults: set wins over a clear, fatal bits never clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      latched_r <= 32'h00000000;
    end else begin
      latched_r <= (latched_r & ~clr_bits) | (event_w & mask_r); // [RQ13] [RQ18] [RQ22] [RQ23]
    end
  end

  // drive disable: latched faults, or self-recovering live conditions
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      disable_r <= 1'b0;
    end else begin
      disable_r <= (|latched_r) || short_off // [RQ14] [RQ15] [RQ21]
        || amp_over_temp // [RQ16]
        || event_w[`DFM_EV_MOTOR_TEMP] // [RQ17]
        || phasing_error; // [RQ20]
    end
  end

  // unlatched tracking error aborts the move once, drive stays enabled
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= track_r && !track_d_r && !mask_r[`DFM_EV_TRACKING]; // [RQ21]
    end
  end

  // history port: push on signalled error, clear on a zero count write
  assign hist_sel = dfm_hit(obj_index, `DFM_IDX_HISTORY);
  assign hist.push = err_signal;
  assign hist.push_data = {err_info, err_code}; // [RQ10]
  assign hist.clear = obj_wr && hist_sel && obj_subindex == 8'h00 && obj_wdata == 32'h00000000; // [RQ9]
  assign hist.rd_sel = (obj_subindex > 8'h08) ? 4'hF : obj_subindex[3:0];

  // object read and answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      hist_rd_r <= 1'b0;
    end else begin
      ack_r <= obj_wr || obj_rd;
      hist_rd_r <= obj_rd && hist_sel;
      err_r <= 1'b0;
      rdata_r <= 32'h00000000;
      if (obj_rd) begin
        unique case (obj_index)
          `DFM_IDX_SUMMARY: rdata_r <= {24'h000000, summary_r};
          `DFM_IDX_MASK: rdata_r <= mask_r; // [RQ26]
          `DFM_IDX_LATCHED: rdata_r <= latched_r;
          `DFM_IDX_WINDOW: rdata_r <= window_r;
          `DFM_IDX_HISTORY: err_r <= obj_subindex > 8'h08;
          default: err_r <= 1'b1;
        endcase
      end else if (obj_wr) begin
        unique case (obj_index)
          `DFM_IDX_MASK, `DFM_IDX_LATCHED, `DFM_IDX_WINDOW: err_r <= 1'b0;
          `DFM_IDX_HISTORY: err_r <= obj_subindex != 8'h00 || obj_wdata != 32'h00000000; // [RQ9]
          default: err_r <= 1'b1;
        endcase
      end
    end
  end

  assign obj_ack = ack_r;
  assign obj_err = err_r;
  assign obj_rdata = hist_rd_r ? hist.rd_data : rdata_r;
  assign error_summary = summary_r;
  assign latched_faults = latched_r;
  assign tracking_warning = track_r; // [RQ12]
  assign fault_flag = |latched_r; // [RQ24]
  assign amp_disable = disable_r;
  assign abort_move = abort_r;
endmodule

// [dv/dfm_fault_manager_properties.sv]
`timescale 1ns/1ps
module dfm_fault_manager_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic short_circuit,
  input wire logic encoder_overcurrent,
  input wire logic bus_over_voltage,
  input wire logic bus_under_voltage,
  input wire logic amp_over_temp,
  input wire logic motor_temp_input,
  input wire logic motor_temp_enabled,
  input wire logic [7:0] error_summary,
  input wire logic [31:0] latched_faults,
  input wire logic fault_flag,
  input wire logic abort_move
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // access answer timing
  AST_ACK_LAT: assert property ((obj_wr || obj_rd) |=> obj_ack) else $error("no ack");
  AST_ACK_CAUSE: assert property (obj_ack |-> $past(obj_wr || obj_rd)) else $error("stray ack");
  AST_ERR_ACK: assert property (obj_err |-> obj_ack) else $error("err without ack");
  // summary bits follow live conditions one cycle later
  AST_SUM_CUR: assert property (
    error_summary[1] == $past(short_circuit || encoder_overcurrent))
    else $error("current bit wrong");
  AST_SUM_VOLT: assert property (
    error_summary[2] == $past(bus_over_voltage || bus_under_voltage))
    else $error("voltage bit wrong");
  AST_SUM_TEMP: assert property (
    error_summary[3] == $past(amp_over_temp || (motor_temp_input && motor_temp_enabled)))
    else $error("temp bit");
  AST_SUM_GEN: assert property (|error_summary[7:1] |-> error_summary[0])
    else $error("generic bit missing");
  AST_SUM_RSV: assert property (error_summary[6:4] == 3'h0) else $error("reserved set");
  AST_FLAG: assert property (fault_flag == |latched_faults) else $error("fault flag");
  AST_LATCH_RSV: assert property (latched_faults[31:13] == 19'h0) else $error("rsv latch");
  AST_ABORT: assert property (abort_move |=> !abort_move) else $error("abort too long");
endmodule

bind dfm_fault_manager dfm_fault_manager_properties chk_u (.core_clk, .reset_n, .obj_wr,
  .obj_rd, .obj_ack, .obj_err, .short_circuit, .encoder_overcurrent, .bus_over_voltage,
  .bus_under_voltage, .amp_over_temp, .motor_temp_input, .motor_temp_enabled,
  .error_summary, .latched_faults, .fault_flag, .abort_move);

// [dv/dfm_net_master.sv]
`timescale 1ns/1ps
module dfm_net_master (
  input wire logic core_clk,
  output logic obj_wr,
  output logic obj_rd,
  output logic [15:0] obj_index,
  output logic [7:0] obj_subindex,
  output logic [31:0] obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err
);
  initial begin
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    obj_index = 16'h0;
    obj_subindex = 8'h0;
    obj_wdata = 32'h0;
  end
  // one request pulse, qualifiers held until the answer, answer within 4 edges
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, output logic [31:0] rd, output logic er, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    er = 1'b0;
    @(posedge core_clk);
    obj_wr <= wr;
    obj_rd <= !wr;
    obj_index <= idx;
    obj_subindex <= sub;
    obj_wdata <= wd;
    @(posedge core_clk);
    obj_wr <= 1'b0;
    obj_rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge core_clk);
      if (obj_ack === 1'b1) begin
        ok = 1'b1;
        rd = obj_rdata;
        er = obj_err;
      end
    end
  endtask
endmodule

// [dv/dfm_fault_manager_tb.sv]
`timescale 1ns/1ps
`include "dfm_defines.svh"
module dfm_fault_manager_tb;
  import dfm_pkg::*;
  localparam logic [14:0] ROWS [0:11] = '{15'h0001, 15'h0002, 15'h0004, 15'h0008, 15'h0010,
    15'h0020, 15'h0040, 15'h0C00, 15'h0800, 15'h0080, 15'h0100, 15'h0200};
  localparam logic [7:0] SUMS [0:11] = '{8'h03, 8'h03, 8'h05, 8'h05, 8'h09, 8'h81, 8'h81,
    8'h09, 8'h00, 8'h01, 8'h01, 8'h01};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [14:0] cnd = 15'h0;
  logic signed [31:0] pos_err = 32'sh0;
  logic err_signal = 1'b0;
  logic [15:0] err_code = 16'h0;
  logic [15:0] err_info = 16'h0;
  logic obj_wr, obj_rd, obj_ack, obj_err, tracking_warning, fault_flag, amp_disable, abort_move;
  logic [15:0] obj_index;
  logic [7:0] obj_subindex, error_summary;
  logic [31:0] obj_wdata, obj_rdata, latched_faults;
  int n_errors = 0;
  int n_tests = 0;
  // network master drives the object bus
  dfm_net_master master_u (.core_clk(core_clk), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
    .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
  dfm_fault_manager #(.SHORT_CYC(20)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index), .obj_subindex(obj_subindex),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .crc_fail(cnd[12]), .selftest_fail(cnd[13]), .fpga_fail(cnd[14]),
    .short_circuit(cnd[0]), .encoder_overcurrent(cnd[1]), .feedback_loss(cnd[7]),
    .bus_over_voltage(cnd[2]), .bus_under_voltage(cnd[3]), .amp_over_temp(cnd[4]),
    .motor_temp_input(cnd[10]), .motor_temp_enabled(cnd[11]), .phasing_error(cnd[5]),
    .limit_switch(cnd[6]), .i2t_limited(cnd[8]), .command_lost(cnd[9]),
    .position_error(pos_err), .err_signal(err_signal), .err_code(err_code),
    .err_info(err_info), .error_summary(error_summary), .latched_faults(latched_faults),
    .tracking_warning(tracking_warning), .fault_flag(fault_flag),
    .amp_disable(amp_disable), .abort_move(abort_move));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access; error flag always compared, data only on good reads
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic er, ok;
    master_u.xfer(wr, idx, sub, wd, rd, er, ok);
    if (!ok) begin
      n_errors++;
      tally_and_finish();
    end else begin
      chk({31'h0, er}, {31'h0, exp_err});
      if (!wr && !exp_err) chk(rd, exp);
    end
  endtask
  task automatic hold(input logic [14:0] c, input int n);
    cnd <= c;
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    acc(0, `DFM_IDX_MASK, 0, 0, 32'h803, 0);
    acc(0, `DFM_IDX_HISTORY, 0, 0, 0, 0);
    acc(0, 16'h3000, 0, 0, 0, 1);
    acc(1, `DFM_IDX_MASK, 0, 32'hFFFFFFFF, 0, 0);
    acc(0, `DFM_IDX_MASK, 0, 0, 32'h1FFF, 0);
    acc(1, `DFM_IDX_MASK, 0, 0, 0, 0);
    acc(0, `DFM_IDX_MASK, 0, 0, 32'h803, 0);
    // each non-fatal condition alone, nothing latches with mask cleared
    for (int i = 0; i < 12; i++) begin
      hold(ROWS[i], 3);
      chk({24'h0, error_summary}, {24'h0, SUMS[i]});
    end
    hold(0, 3);
    chk({24'h0, error_summary}, 0);
    chk(latched_faults, 0);
    acc(0, `DFM_IDX_SUMMARY, 0, 0, 0, 0);
    // short without latch: outputs off, back on after the off time
    hold(15'h0001, 1);
    hold(0, 10);
    chk({31'h0, amp_disable}, 1);
    repeat (25) @(posedge core_clk);
    chk({31'h0, amp_disable}, 0);
    // amplifier overtemp latched, then cleared by writing one
    acc(1, `DFM_IDX_MASK, 0, 32'h8, 0, 0);
    hold(15'h0010, 3);
    hold(0, 3);
    chk(latched_faults, 32'h8);
    chk({31'h0, fault_flag & amp_disable}, 1);
    acc(1, `DFM_IDX_LATCHED, 0, 32'h8, 0, 0);
    chk(latched_faults, 0);
    // tracking window on both signs, then latched
    acc(1, `DFM_IDX_WINDOW, 0, 32'd10, 0, 0);
    pos_err <= 32'sd11;
    repeat (3) @(posedge core_clk);
    chk({31'h0, tracking_warning}, 1);
    chk(latched_faults, 0);
    chk({31'h0, abort_move}, 1);
    pos_err <= -32'sd11;
    repeat (3) @(posedge core_clk);
    chk({31'h0, tracking_warning}, 1);
    chk({31'h0, abort_move}, 0);
    pos_err <= 32'sd10;
    repeat (3) @(posedge core_clk);
    chk({31'h0, tracking_warning}, 0);
    acc(1, `DFM_IDX_MASK, 0, 32'h200, 0, 0);
    pos_err <= 32'sd11;
    repeat (4) @(posedge core_clk);
    chk({31'h0, amp_disable}, 1);
    chk({31'h0, abort_move}, 0);
    chk(latched_faults, 32'h200);
    pos_err <= 32'sd0;
    acc(1, `DFM_IDX_LATCHED, 0, 32'h200, 0, 0);
    chk(latched_faults, 0);
    // nine errors into an eight deep history
    for (int k = 1; k < 10; k++) begin
      err_code <= 16'(k);
      err_info <= ~16'(k);
      err_signal <= 1'b1;
      @(posedge core_clk);
      err_signal <= 1'b0;
      @(posedge core_clk);
    end
    acc(0, `DFM_IDX_HISTORY, 0, 0, 8, 0);
    acc(0, `DFM_IDX_HISTORY, 1, 0, 32'hFFF60009, 0);
    acc(0, `DFM_IDX_HISTORY, 8, 0, 32'hFFFD0002, 0);
    acc(0, `DFM_IDX_HISTORY, 9, 0, 0, 1);
    acc(1, `DFM_IDX_HISTORY, 0, 1, 0, 1);
    acc(0, `DFM_IDX_HISTORY, 0, 0, 8, 0);
    acc(1, `DFM_IDX_HISTORY, 0, 0, 0, 0);
    acc(0, `DFM_IDX_HISTORY, 0, 0, 0, 0);
    acc(0, `DFM_IDX_HISTORY, 1, 0, 0, 0);
    // every maskable event except tracking latches with its mask bit set, then cleared by writing ones
    acc(1, `DFM_IDX_MASK, 0, 32'h17FC, 0, 0);
    hold(15'h0FBF, 3);
    hold(0, 3);
    chk(latched_faults, 32'h15FC);
    acc(1, `DFM_IDX_LATCHED, 0, 32'h15FC, 0, 0);
    chk(latched_faults, 0);
    // fatal faults stay latched and keep the amplifier off
    hold(15'h7000, 3);
    hold(0, 3);
    acc(1, `DFM_IDX_LATCHED, 0, 32'hFFFFFFFF, 0, 0);
    chk(latched_faults & 32'h803, 32'h803);
    chk({31'h0, amp_disable}, 1);
    tally_and_finish();
  end
endmodule
